/* hdl/pps_shell.sv */
/*
 * power policy interface shell: apb register port, clock quiescence channel, and
 * either one power-mode request channel or several quiescence channels toward devices,
 * plus a power-mode request channel toward the power control state machine.
 * assumes presetn is released in step with pclk and pwakeup comes from a flop.
 */
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Function
// (R1) reset may assert at any time but is released in step with the clock.
// (R2) the bus side drives the wakeup input straight from a flop.
// (R3) wakeup is one term of the clock-channel active output.
// (R4) clock quiescence request is synchronised when its sync parameter is one.
// (R5) clock-channel accept is a registered output agreeing to gate the clock.
// (R6) clock-channel deny is a registered output refusing to gate the clock.
// (R7) clock-channel active is raised whenever the clock is needed.
// (R8) with zero device channels a single power-mode request channel is used.
// (R9) device mode request and its state bus are low in reset.
// (R10) a separate mode request goes to the state machine, low in reset.
// (R11) both state buses carry power mode plus operating mode during a request.
// (R12) device accept and deny are synchronised when the device sync parameter is one.
// (R13) device active bus is synchronised when its sync parameter is one.
// (R14) with nonzero count that many quiescence channels are provided.
// (R15) each active-low quiescence request output comes from a flop.
// (R16) each device answers with active-low accept or deny, synchronised as chosen.
// (R17) each device quiescence active input is synchronised as chosen.
// (R18) state machine answers with accept only, synchronised when its parameter is one.
// (R19) the mode-status bus is used only when the retention parameter is nonzero.
// (R20) state bus is held during a request; release only after accept or deny.
// (R21) asynchronous handshake inputs pass two flops before any use.
module pps_shell
    import pps_pkg::*;
#(
    parameter int device_channel_count_param = 0,
    parameter bit clock_channel_sync_param = 1'b1,
    parameter bit dev_sync_param = 1'b1,
    parameter bit dev_active_sync_param = 1'b1,
    parameter bit pcsm_sync_param = 1'b1,
    parameter bit off_to_retention_param = 1'b0,
    parameter int mode_state_width_param = 8,
    parameter int mode_wish_width_param = 8,
    localparam int QW = (device_channel_count_param > 0) ? device_channel_count_param : 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] paddr,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pwakeup,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_qreqn,
    output logic clk_qacceptn,
    output logic clk_qdeny,
    output logic clk_qactive,
    output logic dev_preq,
    output logic [mode_state_width_param-1:0] dev_pstate,
    input wire logic dev_paccept,
    input wire logic dev_pdeny,
    input wire logic [mode_wish_width_param-1:0] dev_pactive,
    output logic [QW-1:0] dev_qreqn,
    input wire logic [QW-1:0] dev_qacceptn,
    input wire logic [QW-1:0] dev_qdeny,
    input wire logic [QW-1:0] dev_qactive,
    output logic pcsm_preq,
    output logic [mode_state_width_param-1:0] pcsm_pstate,
    input wire logic pcsm_paccept,
    input wire logic [mode_state_width_param-1:0] mode_status_info
);
    localparam bit USE_P = (device_channel_count_param == 0);
    localparam int SW = mode_state_width_param;
    localparam int AW = mode_wish_width_param;

    // synchronised views of the handshake inputs
    logic clk_qreqn_s;
    logic dev_paccept_s;
    logic dev_pdeny_s;
    logic [AW-1:0] dev_pactive_s;
    logic [QW-1:0] dev_qacceptn_s;
    logic [QW-1:0] dev_qdeny_s;
    logic [QW-1:0] dev_qactive_s;
    logic pcsm_paccept_s;

    // acceptn lines reset low in a plain synchroniser, so invert around it to park them high
    logic [QW-1:0] qacc_inv_s;

    pps_sync #(.WIDTH(1), .ASYNC(clock_channel_sync_param)) u_sync_clk ( // (R4) (R21)
        .pclk(pclk), .presetn(presetn), .din(~clk_qreqn), .dout(clk_qreqn_s));
    pps_sync #(.WIDTH(2), .ASYNC(dev_sync_param)) u_sync_pdev ( // (R12) (R21)
        .pclk(pclk), .presetn(presetn), .din({dev_paccept, dev_pdeny}), .dout({dev_paccept_s, dev_pdeny_s}));
    pps_sync #(.WIDTH(AW), .ASYNC(dev_active_sync_param)) u_sync_pact ( // (R13) (R21)
        .pclk(pclk), .presetn(presetn), .din(dev_pactive), .dout(dev_pactive_s));
    pps_sync #(.WIDTH(2 * QW), .ASYNC(dev_sync_param)) u_sync_qdev ( // (R16) (R21)
        .pclk(pclk), .presetn(presetn), .din({~dev_qacceptn, dev_qdeny}), .dout({qacc_inv_s, dev_qdeny_s}));
    pps_sync #(.WIDTH(QW), .ASYNC(dev_active_sync_param)) u_sync_qact ( // (R17) (R21)
        .pclk(pclk), .presetn(presetn), .din(dev_qactive), .dout(dev_qactive_s));
    pps_sync #(.WIDTH(1), .ASYNC(pcsm_sync_param)) u_sync_pcsm ( // (R18) (R21)
        .pclk(pclk), .presetn(presetn), .din(pcsm_paccept), .dout(pcsm_paccept_s));

    assign dev_qacceptn_s = ~qacc_inv_s;

    // apb decode
    logic wr_en;
    logic hit_ctrl;
    logic hit_qctrl;
    logic hit_status;
    logic hit_qstat;
    logic hit_qdeny;
    logic hit_active;
    logic hit_mode_status;
    logic hit_curstate;
    logic hit_any;
    logic [31:0] word_addr;

    assign word_addr = {paddr[31:2], 2'b00};
    assign hit_ctrl = (word_addr == PPS_OFS_CTRL);
    assign hit_qctrl = (word_addr == PPS_OFS_QCTRL);
    assign hit_status = (word_addr == PPS_OFS_STATUS);
    assign hit_qstat = (word_addr == PPS_OFS_QSTAT);
    assign hit_qdeny = (word_addr == PPS_OFS_QDENY);
    assign hit_active = (word_addr == PPS_OFS_ACTIVE);
    assign hit_mode_status = (word_addr == PPS_OFS_MODE_STATUS);
    assign hit_curstate = (word_addr == PPS_OFS_CURSTATE);
    assign hit_any = hit_ctrl | hit_qctrl | hit_status | hit_qstat | hit_qdeny | hit_active
                     | hit_mode_status | hit_curstate;
    assign wr_en = psel & penable & pwrite;

    // software state
    logic [SW-1:0] target_state;
    logic clk_deny_policy;
    logic [QW-1:0] q_target;
    logic p_deny_flag;
    logic p_done_flag;
    logic [QW-1:0] q_deny_flag;
    logic [SW-1:0] cur_state;

    // mode request sequencer
    pps_pstate_t pst;
    pps_pstate_t next_pst;
    logic p_busy;
    logic p_start;
    logic p_set_deny;
    logic p_set_done;
    logic ctrl_refused;

    assign p_busy = (pst != PPS_P_IDLE);
    // a new target while a request is in flight would break the held state bus
    assign ctrl_refused = wr_en & hit_ctrl & p_busy; // (R20)
    assign p_start = wr_en & hit_ctrl & ~p_busy;

    always_comb begin
        next_pst = pst;
        unique case (pst)
            PPS_P_IDLE: begin
                if (p_start) begin
                    next_pst = USE_P ? PPS_P_DEV : PPS_P_PCSM; // (R8)
                end
            end
            PPS_P_DEV: begin
                if (dev_pdeny_s) begin
                    next_pst = PPS_P_REL; // (R20)
                end else if (dev_paccept_s) begin
                    next_pst = PPS_P_PCSM; // (R20)
                end
            end
            PPS_P_PCSM: begin
                if (pcsm_paccept_s && !dev_paccept_s) begin
                    next_pst = PPS_P_REL; // (R18) (R20)
                end
            end
            PPS_P_REL: begin
                if (!pcsm_paccept_s && !dev_paccept_s && !dev_pdeny_s) begin
                    next_pst = PPS_P_IDLE;
                end
            end
        endcase
    end

    assign p_set_deny = (pst == PPS_P_DEV) & dev_pdeny_s;
    assign p_set_done = (pst == PPS_P_PCSM) & (next_pst == PPS_P_REL);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pst <= PPS_P_IDLE;
            dev_preq <= 1'b0; // (R9)
            dev_pstate <= '0; // (R9)
            pcsm_preq <= 1'b0; // (R10)
            pcsm_pstate <= '0;
        end else begin
            pst <= next_pst;
            dev_preq <= USE_P & (next_pst == PPS_P_DEV);
            pcsm_preq <= (next_pst == PPS_P_PCSM); // (R10)
            // take the word being written: target_state only updates at this same edge
            if (p_start) begin
                dev_pstate <= USE_P ? pwdata[SW-1:0] : '0; // (R11)
                pcsm_pstate <= pwdata[SW-1:0]; // (R11)
            end
        end
    end

    // quiescence channels, one requester per bit, all in one process so the vector has one driver
    logic [QW-1:0] q_enter;
    logic [QW-1:0] q_leave;

    assign q_enter = dev_qreqn & dev_qacceptn_s & ~dev_qdeny_s & q_target;
    // leave only once the device has answered one way or the other
    assign q_leave = ~dev_qreqn & (dev_qdeny_s | (~dev_qacceptn_s & ~q_target)); // (R20)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dev_qreqn <= '1;
        end else if (device_channel_count_param > 0) begin // (R14)
            dev_qreqn <= (dev_qreqn & ~q_enter) | q_leave; // (R15)
        end
    end

    // clock quiescence channel
    pps_qresp_t clk_resp;
    logic clk_busy;

    assign clk_busy = p_busy | pwakeup | psel | clk_deny_policy | (|dev_pactive_s) | (|dev_qactive_s)
                      | (|(dev_qreqn ^ ~q_target));
    pps_clk_qresp u_clk_qresp (
        .pclk(pclk),
        .presetn(presetn),
        .qreqn_n(~clk_qreqn_s),
        .busy(clk_busy),
        .resp(clk_resp)
    );
    assign clk_qacceptn = clk_resp.acceptn; // (R5)
    assign clk_qdeny = clk_resp.deny; // (R6)
    // combinational on purpose: raw wakeup and select keep the clock requested before any edge
    assign clk_qactive = pwakeup | psel | clk_busy; // (R3) (R7)

    // registers
    logic [31:0] wdata_mask_q;
    assign wdata_mask_q = pwdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_state <= '0;
            clk_deny_policy <= 1'b0;
            q_target <= '0;
        end else if (wr_en) begin
            if (p_start) begin
                target_state <= pwdata[SW-1:0];
                clk_deny_policy <= pwdata[PPS_CTRL_CLKDENY_BIT];
            end
            if (hit_qctrl) begin
                q_target <= wdata_mask_q[QW-1:0];
            end
        end
    end

    // sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_deny_flag <= 1'b0;
            p_done_flag <= 1'b0;
            q_deny_flag <= '0;
            cur_state <= '0;
        end else begin
            p_deny_flag <= p_set_deny | (p_deny_flag & ~(wr_en & hit_status & pwdata[PPS_STAT_DENY_BIT]));
            p_done_flag <= p_set_done | (p_done_flag & ~(wr_en & hit_status & pwdata[PPS_STAT_DONE_BIT]));
            q_deny_flag <= (~dev_qreqn & dev_qdeny_s)
                           | (q_deny_flag & ~({QW{wr_en & hit_qdeny}} & pwdata[QW-1:0]));
            if (p_set_done) begin
                cur_state <= pcsm_pstate;
            end
        end
    end

    // read data
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [SW-1:0] mode_stat_seen;

    assign mode_stat_seen = off_to_retention_param ? mode_status_info : '0; // (R19)
    always_comb begin
        status_word = PPS_RESET_WORD;
        status_word[PPS_STAT_BUSY_BIT] = p_busy;
        status_word[PPS_STAT_DENY_BIT] = p_deny_flag;
        status_word[PPS_STAT_DONE_BIT] = p_done_flag;
    end

    always_comb begin
        rd_mux = PPS_RESET_WORD;
        if (hit_ctrl) begin
            rd_mux[SW-1:0] = target_state;
            rd_mux[PPS_CTRL_CLKDENY_BIT] = clk_deny_policy;
        end else if (hit_qctrl) begin
            rd_mux[QW-1:0] = q_target;
        end else if (hit_status) begin
            rd_mux = status_word;
        end else if (hit_qstat) begin
            rd_mux[QW-1:0] = ~dev_qacceptn_s & ~dev_qreqn;
        end else if (hit_qdeny) begin
            rd_mux[QW-1:0] = q_deny_flag;
        end else if (hit_active) begin
            rd_mux[AW-1:0] = dev_pactive_s;
            rd_mux[31 -: QW] = dev_qactive_s;
        end else if (hit_mode_status) begin
            rd_mux[SW-1:0] = mode_stat_seen;
        end else if (hit_curstate) begin
            rd_mux[SW-1:0] = cur_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= PPS_RESET_WORD;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & (~hit_any | ctrl_refused);
endmodule : pps_shell

/* hdl/pps_pkg.sv */
/*
 * constants, states and carrier types shared by the power policy interface shell.
 * assumes a 32-bit apb register port with word-aligned registers.
 */
package pps_pkg;

    // register byte offsets
    localparam logic [31:0] PPS_OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] PPS_OFS_QCTRL = 32'h0000_0004;
    localparam logic [31:0] PPS_OFS_STATUS = 32'h0000_0008;
    localparam logic [31:0] PPS_OFS_QSTAT = 32'h0000_000c;
    localparam logic [31:0] PPS_OFS_QDENY = 32'h0000_0010;
    localparam logic [31:0] PPS_OFS_ACTIVE = 32'h0000_0014;
    localparam logic [31:0] PPS_OFS_MODE_STATUS = 32'h0000_0018;
    localparam logic [31:0] PPS_OFS_CURSTATE = 32'h0000_001c;

    // ctrl fields: target state in the low bits, clock deny policy above it
    localparam int PPS_CTRL_CLKDENY_BIT = 16;
    // status fields
    localparam int PPS_STAT_BUSY_BIT = 0;
    localparam int PPS_STAT_DENY_BIT = 1;
    localparam int PPS_STAT_DONE_BIT = 2;
    // requested-state layout: power mode low, operating mode above
    localparam int PPS_PMODE_WIDTH = 4;

    localparam logic [31:0] PPS_RESET_WORD = 32'h0000_0000;

    // mode request sequence, gray coded along the idle, dev, pcsm, rel accept path of the single channel build
    typedef enum logic [1:0] {
        PPS_P_IDLE = 2'b00,
        PPS_P_DEV = 2'b01,
        PPS_P_PCSM = 2'b11,
        PPS_P_REL = 2'b10
    } pps_pstate_t;

    // clock quiescence responder
    typedef enum logic [1:0] {
        PPS_C_RUN = 2'b00,
        PPS_C_STOP = 2'b01,
        PPS_C_DENY = 2'b10
    } pps_cstate_t;

    // answer lines of a quiescence responder
    typedef struct packed {
        logic acceptn;
        logic deny;
    } pps_qresp_t;

endpackage : pps_pkg

/* hdl/pps_sync.sv */
/*
 * optional two-stage synchroniser for a bundle of handshake inputs.
 * assumes the bits are independent levels; a synchronous input passes straight through.
 */
`timescale 1ns/1ps
module pps_sync #(
    parameter int WIDTH = 1,
    parameter bit ASYNC = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    generate
        if (ASYNC) begin : g_two_stage
            logic [WIDTH-1:0] stage1;
            logic [WIDTH-1:0] stage2;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1 <= '0;
                    stage2 <= '0;
                end else begin
                    stage1 <= din;
                    stage2 <= stage1;
                end
            end
            assign dout = stage2;
        end else begin : g_direct
            assign dout = din;
        end
    endgenerate
endmodule : pps_sync

/* hdl/pps_clk_qresp.sv */
/*
 * responder on the clock quiescence channel: accepts or denies gating of its own clock.
 * assumes qreqn_n is already in the pclk domain.
 */
`timescale 1ns/1ps
module pps_clk_qresp
    import pps_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic qreqn_n,
    input wire logic busy,
    output pps_qresp_t resp
);
    pps_cstate_t state;
    pps_cstate_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            PPS_C_RUN: begin
                if (!qreqn_n) begin
                    next_state = busy ? PPS_C_DENY : PPS_C_STOP;
                end
            end
            PPS_C_STOP, PPS_C_DENY: begin
                if (qreqn_n) begin
                    next_state = PPS_C_RUN;
                end
            end
            default: next_state = PPS_C_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PPS_C_RUN;
            resp <= '{acceptn: 1'b1, deny: 1'b0};
        end else begin
            state <= next_state;
            resp.acceptn <= (next_state != PPS_C_STOP); // (R5)
            resp.deny <= (next_state == PPS_C_DENY); // (R6)
        end
    end
endmodule : pps_clk_qresp

/* dv/pps_shell_asserts.sv */
/*
 * port assertions for the power policy interface shell.
 * assumes one clock domain, handshake inputs taken through two sync stages.
 */
`timescale 1ns/1ps
module pps_shell_asserts #(
    parameter int device_channel_count_param = 0,
    parameter int mode_state_width_param = 8,
    parameter int QW = (device_channel_count_param > 0) ? device_channel_count_param : 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic pwakeup,
    input wire logic clk_qreqn,
    input wire logic clk_qacceptn,
    input wire logic clk_qdeny,
    input wire logic clk_qactive,
    input wire logic dev_preq,
    input wire logic [mode_state_width_param-1:0] dev_pstate,
    input wire logic dev_paccept,
    input wire logic dev_pdeny,
    input wire logic [QW-1:0] dev_qreqn,
    input wire logic pcsm_preq,
    input wire logic [mode_state_width_param-1:0] pcsm_pstate,
    input wire logic pcsm_paccept
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_out;
        $rose(presetn) |-> !dev_preq && !pcsm_preq && dev_pstate == '0 && pcsm_pstate == '0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("request outputs not idle after reset");
    property p_wake;
        (pwakeup || psel) |-> clk_qactive;
    endproperty
    a_wake: assert property (p_wake)
        else $error("clock active low with bus wakeup");
    property p_busy;
        (dev_preq || pcsm_preq) |-> clk_qactive;
    endproperty
    a_busy: assert property (p_busy)
        else $error("clock active low during a mode request");
    property p_clk_acc;
        $fell(clk_qacceptn) |-> !clk_qreqn && !$past(clk_qreqn, 2) && !$past(pwakeup);
    endproperty
    a_clk_acc: assert property (p_clk_acc)
        else $error("clock accept without a settled request");
    property p_clk_deny;
        $rose(clk_qdeny) |-> !clk_qreqn && clk_qacceptn;
    endproperty
    a_clk_deny: assert property (p_clk_deny)
        else $error("clock deny without request");
    property p_excl;
        !(clk_qdeny && !clk_qacceptn);
    endproperty
    a_excl: assert property (p_excl)
        else $error("clock accept and deny together");
    property p_dev_rel;
        $fell(dev_preq) |-> (dev_paccept || dev_pdeny) && $past(dev_paccept || dev_pdeny, 2);
    endproperty
    a_dev_rel: assert property (p_dev_rel)
        else $error("device request dropped before its answer");
    property p_pcsm_rel;
        $fell(pcsm_preq) |-> pcsm_paccept && $past(pcsm_paccept, 2);
    endproperty
    a_pcsm_rel: assert property (p_pcsm_rel)
        else $error("state machine request dropped before accept");
    property p_dev_hold;
        dev_preq && $past(dev_preq) |-> $stable(dev_pstate);
    endproperty
    a_dev_hold: assert property (p_dev_hold)
        else $error("state bus moved during a request");
    property p_qch;
        device_channel_count_param != 0 || dev_qreqn == '1;
    endproperty
    a_qch: assert property (p_qch)
        else $error("quiescence request active in single channel build");
endmodule : pps_shell_asserts

/* dv/pps_dev_model.sv */
/*
 * model of the controlled device and the power control state machine.
 * assumes the shell clock; the device answers lag plus one cycles after its request, the state machine one cycle after its request; denies only when told.
 */
`timescale 1ns/1ps
module pps_dev_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dev_preq,
    input wire logic pcsm_preq,
    input wire logic deny_en,
    input wire logic [3:0] lag,
    input wire logic [7:0] wish,
    output logic dev_paccept,
    output logic dev_pdeny,
    output logic pcsm_paccept,
    output logic [7:0] dev_pactive
);
    logic [3:0] cnt;
    wire answered = dev_paccept | dev_pdeny;
    assign dev_pactive = wish;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 4'h0;
            dev_paccept <= 1'b0;
            dev_pdeny <= 1'b0;
            pcsm_paccept <= 1'b0;
        end else begin
            // answer stands until the request drops, so the shell must wait for it
            if (!dev_preq) begin
                cnt <= 4'h0;
                dev_paccept <= 1'b0;
                dev_pdeny <= 1'b0;
            end else if (!answered && cnt == lag) begin
                dev_paccept <= !deny_en;
                dev_pdeny <= deny_en;
            end else if (!answered) begin
                cnt <= cnt + 4'h1;
            end
            pcsm_paccept <= pcsm_preq;
        end
    end
endmodule : pps_dev_model

/* dv/tb_pps_shell.sv */
/*
 * self-checking bench for the shell in its single mode channel build.
 * assumes zero wait apb and the model answering on the mode channels.
 */
`timescale 1ns/1ps
bind pps_shell pps_shell_asserts #(
    .device_channel_count_param(device_channel_count_param),
    .mode_state_width_param(mode_state_width_param)
) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .pwakeup(pwakeup), .clk_qreqn(clk_qreqn),
    .clk_qacceptn(clk_qacceptn), .clk_qdeny(clk_qdeny), .clk_qactive(clk_qactive), .dev_preq(dev_preq),
    .dev_pstate(dev_pstate), .dev_paccept(dev_paccept), .dev_pdeny(dev_pdeny), .dev_qreqn(dev_qreqn),
    .pcsm_preq(pcsm_preq), .pcsm_pstate(pcsm_pstate), .pcsm_paccept(pcsm_paccept));
module tb_pps_shell
    import pps_pkg::*;
;
    typedef struct {logic [7:0] ps; logic dn; logic [3:0] lg; logic [31:0] st;} pps_row_t;
    logic pclk, presetn, psel, penable, pwrite, pwakeup, clk_qreqn, er, deny_en;
    logic [31:0] paddr, pwdata, prdata, rd, cur;
    logic pready, pslverr, clk_qacceptn, clk_qdeny, clk_qactive, dev_preq, dev_paccept, dev_pdeny;
    logic pcsm_preq, pcsm_paccept;
    logic [7:0] dev_pstate, dev_pactive, pcsm_pstate, wish;
    logic [0:0] dev_qreqn;
    logic [3:0] lag;
    int mismatches, n_compared, n;
    // rows: requested state, deny, answer lag, expected status after the sequence
    pps_row_t rows[4] = '{'{8'h21, 1'b0, 4'h0, 32'h4}, '{8'h35, 1'b1, 4'h2, 32'h2},
        '{8'hf0, 1'b0, 4'h5, 32'h4}, '{8'h0f, 1'b1, 4'h0, 32'h2}};

    pps_shell dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
        .pwrite(pwrite), .pwdata(pwdata), .pwakeup(pwakeup), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_qreqn(clk_qreqn), .clk_qacceptn(clk_qacceptn), .clk_qdeny(clk_qdeny),
        .clk_qactive(clk_qactive), .dev_preq(dev_preq), .dev_pstate(dev_pstate), .dev_paccept(dev_paccept),
        .dev_pdeny(dev_pdeny), .dev_pactive(dev_pactive), .dev_qreqn(dev_qreqn),
        .dev_qacceptn(1'b1), .dev_qdeny(1'b0), .dev_qactive(1'b0),
        .pcsm_preq(pcsm_preq), .pcsm_pstate(pcsm_pstate),
        .pcsm_paccept(pcsm_paccept), .mode_status_info(8'h00));
    pps_dev_model u_far (.pclk(pclk), .presetn(presetn), .dev_preq(dev_preq), .pcsm_preq(pcsm_preq),
        .deny_en(deny_en), .lag(lag), .wish(wish), .dev_paccept(dev_paccept), .dev_pdeny(dev_pdeny),
        .pcsm_paccept(pcsm_paccept), .dev_pactive(dev_pactive));

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rst_chk;
        chk(dev_preq, 0);
        chk(dev_pstate, 0);
        chk(pcsm_preq, 0);
        chk(clk_qacceptn, 1);
        chk(clk_qdeny, 0);
    endtask : rst_chk
    task summarize;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        summarize();
    end
    initial begin
        {psel, penable, pwrite, pwakeup, deny_en, presetn} = '0;
        {paddr, pwdata, wish, lag, cur} = '0;
        clk_qreqn = 1'b1;
        repeat (3) @(posedge pclk);
        rst_chk();
        presetn <= 1'b1;
        foreach (rows[i]) begin
            deny_en <= rows[i].dn;
            lag <= rows[i].lg;
            apb(1'b1, PPS_OFS_STATUS, 32'h6, rd, er);
            apb(1'b1, PPS_OFS_CTRL, {24'h0, rows[i].ps}, rd, er);
            for (n = 0; n < 20 && dev_preq !== 1'b1; n++) @(posedge pclk);
            chk(dev_pstate, rows[i].ps);
            chk(pcsm_pstate, rows[i].ps);
            n = 0;
            do begin
                apb(1'b0, PPS_OFS_STATUS, 0, rd, er);
                n++;
            end while (rd[0] !== 1'b0 && n < 40);
            chk(rd, rows[i].st);
            if (!rows[i].dn)
                cur = rows[i].ps;
            apb(1'b0, PPS_OFS_CURSTATE, 0, rd, er);
            chk(rd, cur);
        end
        $display("test mode rows done");
        wish <= 8'h5a;
        apb(1'b0, PPS_OFS_ACTIVE, 0, rd, er);
        apb(1'b0, PPS_OFS_ACTIVE, 0, rd, er);
        chk(rd, 32'h5a);
        wish <= 8'h00;
        apb(1'b0, 32'h40, 0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        $display("test active and unmapped done");
        pwakeup <= 1'b1;
        clk_qreqn <= 1'b0;
        for (n = 0; n < 10 && clk_qdeny !== 1'b1; n++) @(posedge pclk);
        chk(clk_qdeny, 1);
        chk(clk_qactive, 1);
        clk_qreqn <= 1'b1;
        for (n = 0; n < 10 && clk_qdeny !== 1'b0; n++) @(posedge pclk);
        chk(clk_qacceptn, 1);
        pwakeup <= 1'b0;
        @(posedge pclk);
        clk_qreqn <= 1'b0;
        for (n = 0; n < 10 && clk_qacceptn !== 1'b0; n++) @(posedge pclk);
        chk({clk_qacceptn, clk_qdeny, clk_qactive}, 0);
        clk_qreqn <= 1'b1;
        for (n = 0; n < 10 && clk_qacceptn !== 1'b1; n++) @(posedge pclk);
        chk(clk_qacceptn, 1);
        $display("test clock channel done");
        lag <= 4'h8;
        deny_en <= 1'b0;
        apb(1'b1, PPS_OFS_CTRL, 32'h33, rd, er);
        apb(1'b1, PPS_OFS_CTRL, 32'h44, rd, er);
        chk(er, 1);
        chk(dev_preq, 1);
        presetn <= 1'b0;
        @(posedge pclk);
        rst_chk();
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rst_chk();
        $display("test mid-run reset done");
        summarize();
    end
endmodule : tb_pps_shell
